// ===== adc_ctrl.sv
// Purpose: Sequencing and output interface of a pipelined 14-bit converter
// Assumes: pclk is the sample clock; control pins are asynchronous to it
// Notes:   Samples are taken on the rising edge; the front-end code is same-domain

`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Sample clock also steps the state machine; gaps corrupt pipeline samples.
// - Reset level held two cycles or more resets the device.
// - Calibrate level held two cycles or more starts a calibration run.
// - A calibration run lasts its fixed cycle count unless a reset or sleep cuts it short.
// - Output words are junk during reset or calibrate and thirteen cycles after.
// - Read enable low drives data outputs; high floats them.
// - Sleep request low holds low power; release resumes after wake-up time.
// - Sleep destroys the pipeline; outputs stay invalid until recalibration.
// - Valid strobe is low whenever data is valid, never during reset.
// - Each output word is fourteen bits, two's complement.
// - One sample is taken and one word produced per clock.
// - Each word appears thirteen clocks after its sample.
// - Codes beyond full scale saturate to the extreme codes.
module adc_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int CAL_LEN   = adc_ctrl_pkg::CAL_CYCLES,
   parameter int WAKE_LEN  = adc_ctrl_pkg::WAKE_CYCLES,
   parameter int DEPTH     = adc_ctrl_pkg::PIPE_DEPTH
) (
   // Clock and reset
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   // APB slave
   input  wire logic [adc_ctrl_pkg::APB_AW-1:0]   paddr,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [adc_ctrl_pkg::APB_DW-1:0]   pwdata,
   input  wire logic [3:0]                        pstrb,
   output logic      [adc_ctrl_pkg::APB_DW-1:0]   prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   // Control pins
   input  wire logic                              reset_pin,
   input  wire logic                              cal_pin,
   input  wire logic                              read_enable_n,
   input  wire logic                              sleep_request_n,
   // Quantiser code from the analog front end
   input  wire logic signed [adc_ctrl_pkg::CODE_W-1:0] sample_code,
   // Sample outputs
   output logic      [adc_ctrl_pkg::DATA_W-1:0]   data_out,
   output logic                                   data_oe,
   output logic                                   eoc_n
);

   import adc_ctrl_pkg::*;

   localparam int CW = $clog2(CAL_LEN + 1);
   localparam int WW = $clog2(WAKE_LEN + 1);
   localparam int IW = $clog2(INVALID_CYCLES + 1);
   localparam int HW = $clog2(HOLD_MIN_CYCLES + 1);

   // ==========================================================
   // State record
   typedef struct packed {
      logic                         rst_s1;
      logic                         rst_s2;
      logic                         cal_s1;
      logic                         cal_s2;
      logic                         rd_s1;
      logic                         rd_s2;
      logic                         pd_s1;
      logic                         pd_s2;
      logic [HW-1:0]                rst_hold;
      logic [HW-1:0]                cal_hold;
      mode_type                     mode;
      logic [CW-1:0]                cal_cnt;
      logic [WW-1:0]                wake_cnt;
      logic [IW-1:0]                inv_cnt;
      logic                         stale;
      logic [1:0]                   ctrl;
      logic [DEPTH-1:0][DATA_W-1:0] pipe;
      logic                         oe;
      logic                         eoc_n;
   } state_type;

   state_type st_ff;
   state_type nxt_st;

   // ==========================================================
   // Helpers
   function automatic logic [DATA_W-1:0] saturate(
      input logic signed [CODE_W-1:0] code
   );
      logic signed [CODE_W-1:0] hi;
      logic signed [CODE_W-1:0] lo;
      hi = CODE_W'(signed'((1 << (DATA_W - 1)) - 1));
      lo = -hi - CODE_W'(signed'(1));
      if (code > hi) begin
         saturate = {1'b0, {(DATA_W - 1){1'b1}}};
      end else if (code < lo) begin
         saturate = {1'b1, {(DATA_W - 1){1'b0}}};
      end else begin
         saturate = code[DATA_W-1:0];
      end
   endfunction

   function automatic logic [HW-1:0] hold_step(
      input logic          level,
      input logic [HW-1:0] cnt
   );
      if (!level) begin
         hold_step = '0;
      end else if (cnt < HW'(HOLD_MIN_CYCLES)) begin
         hold_step = cnt + HW'(1);
      end else begin
         hold_step = cnt;
      end
   endfunction

   // ==========================================================
   // APB decode
   logic                 access;
   logic                 wr_ctrl;
   logic                 mapped;
   logic                 reset_level;
   logic                 cal_level;
   logic                 reset_ok;
   logic                 cal_ok;
   logic [APB_DW-1:0]    rd_word;

   assign access  = psel & penable;
   assign pready  = 1'b1;
   assign wr_ctrl = access & pwrite & pstrb[0] & (paddr == ADDR_CTRL);

   always_comb begin
      mapped  = 1'b1;
      rd_word = '0;
      if (paddr == ADDR_CTRL) begin
         rd_word[1:0] = st_ff.ctrl;
      end else if (paddr == ADDR_STATUS) begin
         rd_word[STAT_MODE_LSB +: 3]  = st_ff.mode;
         rd_word[STAT_EOC_BIT]        = st_ff.eoc_n;
         rd_word[STAT_STALE_BIT]      = st_ff.stale;
         rd_word[STAT_OE_BIT]         = st_ff.oe;
         rd_word[STAT_INV_LSB +: IW]  = st_ff.inv_cnt;
      end else if (paddr == ADDR_SAMPLE) begin
         rd_word[DATA_W-1:0] = st_ff.pipe[DEPTH-1];
      end else if (paddr == ADDR_CALCNT) begin
         rd_word[CW-1:0] = st_ff.cal_cnt;
      end else begin
         mapped = 1'b0;
      end
   end

   assign prdata  = (access & ~pwrite) ? rd_word : '0;
   assign pslverr = access & ~mapped;

   // Software bits act alongside the pins
   assign reset_level = st_ff.rst_s2 | st_ff.ctrl[CTRL_RST_BIT];
   assign cal_level   = st_ff.cal_s2 | st_ff.ctrl[CTRL_CAL_BIT];
   assign reset_ok    = reset_level & (st_ff.rst_hold >= HW'(HOLD_MIN_CYCLES - 1));
   assign cal_ok      = cal_level & (st_ff.cal_hold >= HW'(HOLD_MIN_CYCLES - 1));

   // ==========================================================
   // Next state
   always_comb begin
      nxt_st = st_ff;

      // Two-stage synchronisers for the pins
      nxt_st.rst_s1 = reset_pin;
      nxt_st.rst_s2 = st_ff.rst_s1;
      nxt_st.cal_s1 = cal_pin;
      nxt_st.cal_s2 = st_ff.cal_s1;
      nxt_st.rd_s1  = read_enable_n;
      nxt_st.rd_s2  = st_ff.rd_s1;
      nxt_st.pd_s1  = sleep_request_n;
      nxt_st.pd_s2  = st_ff.pd_s1;

      nxt_st.rst_hold = hold_step(reset_level, st_ff.rst_hold);
      nxt_st.cal_hold = hold_step(cal_level, st_ff.cal_hold);

      if (wr_ctrl) begin
         nxt_st.ctrl = pwdata[1:0];
      end

      // Pipeline steps every clock outside sleep, so a missing edge leaves stale words
      nxt_st.pipe[0] = saturate(sample_code);
      for (int i = 1; i < DEPTH; i++) begin
         nxt_st.pipe[i] = st_ff.pipe[i-1];
      end

      case (st_ff.mode)
         ST_RUN: begin
            if (reset_ok) begin
               nxt_st.mode = ST_RESET;
            end else if (cal_ok) begin
               nxt_st.mode    = ST_CAL;
               nxt_st.cal_cnt = CW'(CAL_LEN - 1);
            end
         end
         ST_RESET: begin
            if (!reset_level) begin
               nxt_st.mode = ST_RUN;
            end
         end
         ST_CAL: begin
            if (reset_ok) begin
               nxt_st.mode    = ST_RESET;
               nxt_st.cal_cnt = '0;
            end else if (st_ff.cal_cnt == '0) begin
               nxt_st.mode  = ST_RUN;
               nxt_st.stale = 1'b0;
            end else begin
               nxt_st.cal_cnt = st_ff.cal_cnt - CW'(1);
            end
         end
         ST_SLEEP: begin
            // Nothing runs while asleep; pipeline held cleared
            nxt_st.pipe = '0;
            if (st_ff.pd_s2) begin
               nxt_st.mode     = ST_WAKE;
               nxt_st.wake_cnt = WW'(WAKE_LEN - 1);
            end
         end
         ST_WAKE: begin
            if (st_ff.wake_cnt == '0) begin
               nxt_st.mode = ST_RUN;
            end else begin
               nxt_st.wake_cnt = st_ff.wake_cnt - WW'(1);
            end
         end
         default: begin
            nxt_st.mode = ST_RUN;
         end
      endcase

      // Sleep request overrides every other mode
      if (!st_ff.pd_s2 && st_ff.mode != ST_SLEEP) begin
         nxt_st.mode     = ST_SLEEP;
         nxt_st.stale    = 1'b1;
         nxt_st.cal_cnt  = '0;
         nxt_st.wake_cnt = '0;
      end

      // Invalid window covers the levels, the runs and the drain after
      if (reset_level || cal_level || nxt_st.mode != ST_RUN) begin
         nxt_st.inv_cnt = IW'(INVALID_CYCLES);
      end else if (st_ff.inv_cnt != '0) begin
         nxt_st.inv_cnt = st_ff.inv_cnt - IW'(1);
      end

      // Strobe low only with a trustworthy word on the outputs
      nxt_st.eoc_n = !(nxt_st.mode == ST_RUN &&
                       nxt_st.inv_cnt == '0 &&
                       !nxt_st.stale);
      nxt_st.oe    = ~st_ff.rd_s2;
   end

   // ==========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff          <= '0;
         st_ff.rd_s1    <= 1'b1;
         st_ff.rd_s2    <= 1'b1;
         st_ff.pd_s1    <= 1'b1;
         st_ff.pd_s2    <= 1'b1;
         st_ff.mode     <= ST_RESET;
         st_ff.inv_cnt  <= IW'(INVALID_CYCLES);
         st_ff.ctrl     <= CTRL_RESET_VAL;
         st_ff.eoc_n    <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Outputs
   assign data_out = st_ff.pipe[DEPTH-1];
   assign data_oe  = st_ff.oe;
   assign eoc_n    = st_ff.eoc_n;

endmodule // adc_ctrl

`default_nettype wire

// ===== adc_ctrl_pkg.sv
// Purpose: Shared constants and types of the converter control block
// Assumes: One sample clock, APB register access with 32-bit data
// Notes:   Offsets are byte addresses of aligned words

package adc_ctrl_pkg;

   // ==========================================================
   // Bus geometry
   localparam int          APB_AW          = 8;
   localparam int          APB_DW          = 32;

   // ==========================================================
   // Register offsets
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_STATUS     = 8'h04;
   localparam logic [7:0]  ADDR_SAMPLE     = 8'h08;
   localparam logic [7:0]  ADDR_CALCNT     = 8'h0C;

   // ==========================================================
   // Control fields and reset value
   localparam int          CTRL_RST_BIT    = 0;
   localparam int          CTRL_CAL_BIT    = 1;
   localparam logic [1:0]  CTRL_RESET_VAL  = 2'h0;

   // ==========================================================
   // Status fields
   localparam int          STAT_MODE_LSB   = 0;
   localparam int          STAT_EOC_BIT    = 3;
   localparam int          STAT_STALE_BIT  = 4;
   localparam int          STAT_OE_BIT     = 5;
   localparam int          STAT_INV_LSB    = 8;

   // ==========================================================
   // Data format and timing counts
   localparam int          DATA_W          = 14;
   localparam int          CODE_W          = 16;
   localparam int          PIPE_DEPTH      = 13;
   localparam int          INVALID_CYCLES  = 13;
   localparam int          HOLD_MIN_CYCLES = 2;
   localparam int          CAL_CYCLES      = 272800;
   localparam int          WAKE_CYCLES     = 64;

   // ==========================================================
   // Operating modes
   typedef enum logic [2:0] {
      ST_RUN   = 3'b000,
      ST_RESET = 3'b001,
      ST_CAL   = 3'b010,
      ST_SLEEP = 3'b011,
      ST_WAKE  = 3'b100
   } mode_type;

endpackage

// ===== adc_ctrl_sva.sv
// Purpose: Port-level checker for the converter control block
// Assumes: Sees only the top module ports, one clock domain
// Notes:   Bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_sva (
   // Clock and reset
   input wire logic                                     pclk,
   input wire logic                                     presetn,
   // Bus and pins
   input wire logic [adc_ctrl_pkg::APB_AW-1:0]          paddr,
   input wire logic                                     psel,
   input wire logic                                     penable,
   input wire logic                                     pslverr,
   input wire logic                                     reset_pin,
   input wire logic                                     cal_pin,
   input wire logic                                     read_enable_n,
   input wire logic                                     sleep_request_n,
   input wire logic signed [adc_ctrl_pkg::CODE_W-1:0]   sample_code,
   input wire logic [adc_ctrl_pkg::DATA_W-1:0]          data_out,
   input wire logic                                     data_oe,
   input wire logic                                     eoc_n
);
   import adc_ctrl_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Output enable and valid strobe
   // Synchroniser restarts at reset release, so the first window needs reset already gone
   property p_oe_on; (presetn && !read_enable_n) ##1 !read_enable_n [*3] |-> data_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("outputs not driven");
   property p_oe_off; read_enable_n [*4] |-> !data_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("outputs not floated");
   property p_rst_quiet; reset_pin [*4] |-> eoc_n; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("valid during reset");
   property p_cal_quiet; cal_pin [*4] |-> eoc_n; endproperty
   a_cal_quiet: assert property (p_cal_quiet) else $error("valid during calibrate");
   property p_sleep_quiet; !sleep_request_n [*4] |-> eoc_n; endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("valid in sleep");
   property p_rst_tail; reset_pin [*4] ##1 !reset_pin |-> eoc_n [*8]; endproperty
   a_rst_tail: assert property (p_rst_tail) else $error("valid too soon after reset");
   property p_wake_stale; !sleep_request_n [*4] ##1 sleep_request_n |-> eoc_n [*8]; endproperty
   a_wake_stale: assert property (p_wake_stale) else $error("valid right after wake");
   // ==========================================================
   // Sample pipeline, bus error and covers
   property p_pipe;
      (!eoc_n && sample_code inside {[-8192:8191]}) ##13 !eoc_n |-> data_out == 14'($past(sample_code, 13));
   endproperty
   a_pipe: assert property (p_pipe) else $error("word or latency wrong");
   property p_sat_hi; (!eoc_n && sample_code > 8191) ##13 !eoc_n |-> data_out == 14'h1FFF; endproperty
   a_sat_hi: assert property (p_sat_hi) else $error("no positive clip");
   property p_sat_lo; (!eoc_n && sample_code < -8192) ##13 !eoc_n |-> data_out == 14'h2000; endproperty
   a_sat_lo: assert property (p_sat_lo) else $error("no negative clip");
   property p_slverr; psel && penable && paddr > 8'h0C |-> pslverr; endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access accepted");
   c_valid_drop: cover property (!eoc_n ##1 eoc_n);
   c_float: cover property (data_oe ##1 !data_oe);
   c_err: cover property (pslverr);
endmodule // adc_ctrl_sva
`default_nettype wire

// ===== host_capture.sv
// Purpose: Host side model that resolves the data pins and captures words
// Assumes: Floating pins show the inverse of the last driven word
// Notes:   Capture on the rising sample clock edge
`timescale 1ns/10ps
`default_nettype none
module host_capture (
   // Clock and converter pins
   input  wire logic                             pclk,
   input  wire logic [adc_ctrl_pkg::DATA_W-1:0]  data_out,
   input  wire logic                             data_oe,
   input  wire logic                             eoc_n,
   // Resolved bus and captured word
   output logic      [adc_ctrl_pkg::DATA_W-1:0]  data_bus,
   output logic      [adc_ctrl_pkg::DATA_W-1:0]  word_ff,
   output logic                                  got_ff
);
   import adc_ctrl_pkg::*;
   logic [DATA_W-1:0] last_ff = '0;
   // Inverse, not last value, so a stale word never passes
   always_comb data_bus = data_oe ? data_out : ~last_ff;
   always_ff @(posedge pclk) begin
      if (data_oe) last_ff <= data_out;
      word_ff <= data_bus;
      got_ff  <= !eoc_n && data_oe;
   end
endmodule // host_capture
`default_nettype wire

// ===== pipelined_adc_digital_control_bench.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: Short calibration and wake counts
// Notes:   One task per scenario
`timescale 1ns/10ps
`default_nettype none
module pipelined_adc_digital_control_bench;
   import adc_ctrl_pkg::*;
   localparam int CAL_LEN = 40;
   localparam int WAKE_LEN = 4;
   logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic               reset_pin = 0, cal_pin = 0, read_enable_n = 0, sleep_request_n = 1;
   logic [7:0]         paddr = '0;
   logic [31:0]        pwdata = '0, prdata, rd;
   logic [3:0]         pstrb = 4'hF;
   logic signed [15:0] sample_code = '0;
   logic               pready, pslverr, data_oe, eoc_n, got_ff, er;
   logic [13:0]        data_out, data_bus, word_ff;
   int                 err_count = 0, checks_done = 0;
   always #5 pclk = ~pclk;
   adc_ctrl #(.CAL_LEN(CAL_LEN), .WAKE_LEN(WAKE_LEN)) DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .reset_pin, .cal_pin, .read_enable_n, .sleep_request_n,
      .sample_code, .data_out, .data_oe, .eoc_n);
   host_capture host (.pclk, .data_out, .data_oe, .eoc_n, .data_bus, .word_ff, .got_ff);
   // ==========================================================
   // Helpers
   task cyc(input int n); repeat (n) @(posedge pclk); endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      // Own setup edge, so back-to-back calls never drive psel twice in one step
      @(posedge pclk) psel <= 1; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task stop_test;
      $display("err_count=%0d checks_done=%0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task t_regs;
      @(posedge pclk) apb(0, ADDR_CTRL, 0); chk(rd, 32'(CTRL_RESET_VAL));
      apb(0, 8'h10, 0); chk({rd[30:0], er}, 1);
      apb(1, ADDR_CTRL, 1); cyc(4);
      apb(0, ADDR_STATUS, 0); chk(rd[3:0], {1'b1, ST_RESET});
      apb(1, ADDR_CTRL, 0); cyc(20);
      apb(0, ADDR_STATUS, 0); chk(rd[3:0], {1'b0, ST_RUN});
      // Soft calibration right after the soft reset above
      apb(1, ADDR_CTRL, 2); apb(0, ADDR_CALCNT, 0); chk(rd, 32'(CAL_LEN - 1));
      apb(0, ADDR_STATUS, 0); chk(rd[3:0], {1'b1, ST_CAL});
      apb(1, ADDR_CTRL, 0); cyc(CAL_LEN + 20); chk(eoc_n, 0);
   endtask
   task t_stream;
      logic signed [15:0] cin [6] = '{16'sd100, -16'sd5, 16'sd9000, -16'sd9000, 16'sd8191, -16'sd8192};
      logic [13:0] exp [6] = '{14'h0064, 14'h3FFB, 14'h1FFF, 14'h2000, 14'h1FFF, 14'h2000};
      for (int i = 0; i < 6; i++) begin
         @(posedge pclk) sample_code <= cin[i];
         cyc(16);
         chk({got_ff, word_ff}, {1'b1, exp[i]});
         apb(0, ADDR_SAMPLE, 0); chk(rd, 32'(exp[i]));
      end
   endtask
   task t_oe;
      @(posedge pclk) read_enable_n <= 1; cyc(5);
      // Last streamed word was the negative clip code
      chk({data_oe, data_bus}, {1'b0, ~14'h2000});
      read_enable_n <= 0; cyc(5);
      chk({data_oe, data_bus}, {1'b1, 14'h2000});
   endtask
   task t_cal;
      int n;
      n = 0;
      @(posedge pclk) reset_pin <= 1; cyc(6);
      reset_pin <= 0; cyc(3);
      cal_pin <= 1; cyc(6);
      cal_pin <= 0;
      while (eoc_n !== 1'b0 && n < CAL_LEN + 100) begin @(posedge pclk); n++; end
      chk(n >= CAL_LEN + 10 && n <= CAL_LEN + 20, 1);
   endtask
   task t_sleep;
      @(posedge pclk) sleep_request_n <= 0; cyc(8);
      apb(0, ADDR_STATUS, 0); chk(rd[3:0], {1'b1, ST_SLEEP});
      sleep_request_n <= 1; cyc(WAKE_LEN + 30);
      chk(eoc_n, 1);
      apb(0, ADDR_STATUS, 0); chk(rd[5:0], {1'b1, 1'b1, 1'b1, ST_RUN});
      t_cal;
      chk(eoc_n, 0);
   endtask
   initial begin
      cyc(16);
      presetn <= 1;
      cyc(2);
      t_regs;
      t_stream;
      t_oe;
      t_cal;
      t_sleep;
      t_stream;
      stop_test;
   end
   initial begin
      #400000;
      err_count++;
      stop_test;
   end
endmodule // pipelined_adc_digital_control_bench
bind adc_ctrl adc_ctrl_sva u_sva (.pclk, .presetn, .paddr, .psel, .penable, .pslverr, .reset_pin, .cal_pin,
   .read_enable_n, .sleep_request_n, .sample_code, .data_out, .data_oe, .eoc_n);
`default_nettype wire
